/* crcd_byte_classify.sv */
`timescale 1ns/1ps
`include "crcd_map.svh"
module crcd_byte_classify (
  input wire logic [7:0] cmd_byte,
  output crcd_pkg::crcd_kind_e kind,
  output crcd_pkg::crcd_sel_t sel,
  output logic is_read
);
  always_comb begin
    kind = crcd_pkg::CRCD_KIND_NONE;
    if (cmd_byte[7:6] == `CRCD_TOP_BITS) begin
      if (cmd_byte[2:0] == `CRCD_LOW_OFFSET) begin
        kind = crcd_pkg::CRCD_KIND_OFFSET;
      end else if (cmd_byte[2:0] == `CRCD_LOW_GAIN) begin
        kind = crcd_pkg::CRCD_KIND_GAIN;
      end
    end
    sel = {cmd_byte[`CRCD_SEL_HI_BIT], cmd_byte[`CRCD_SEL_LO_BIT]};
    is_read = (cmd_byte[`CRCD_RW_BIT] == `CRCD_RW_READ);
  end
endmodule

/* crcd_decoder.sv */
`timescale 1ns/1ps
`include "crcd_map.svh"
// What this block does
// - Read/write bit: 0 writes the selected register, 1 reads it.
// - Offset command select 00 picks offset register one, 01 register two.
// - Offset select 10 and 11 pick registers three, four; four-channel only.
// - Gain access byte: 00, select, read/write, then low bits 010.
// - Gain select 00 to 11 picks gain registers one to four; 10, 11 four-channel only.
module crcd_decoder #(
  parameter int NUM_CHANNELS = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic offset_wr,
  output logic offset_rd,
  output logic gain_wr,
  output logic gain_rd,
  output logic [3:0] reg_onehot,
  output logic cmd_unknown
);
  if (NUM_CHANNELS != 2 && NUM_CHANNELS != 4) begin : g_bad_channels
    $error("NUM_CHANNELS must be 2 or 4");
  end

  crcd_pkg::crcd_kind_e kind;
  crcd_pkg::crcd_sel_t sel;
  logic is_read;
  logic sel_ok;
  logic offset_wr_r, offset_rd_r, gain_wr_r, gain_rd_r, cmd_unknown_r;
  logic offset_wr_nxt, offset_rd_nxt, gain_wr_nxt, gain_rd_nxt, cmd_unknown_nxt;
  logic [3:0] reg_onehot_r, reg_onehot_nxt;

  crcd_byte_classify u_classify (
    .cmd_byte(cmd_byte),
    .kind(kind),
    .sel(sel),
    .is_read(is_read)
  );

  // Registers three and four missing on the two-channel variant
  assign sel_ok = (NUM_CHANNELS == 4) || (sel[1] == 1'b0);

  always_comb begin
    offset_wr_nxt = 1'b0;
    offset_rd_nxt = 1'b0;
    gain_wr_nxt = 1'b0;
    gain_rd_nxt = 1'b0;
    cmd_unknown_nxt = 1'b0;
    reg_onehot_nxt = 4'h0;
    if (cmd_valid) begin
      if (kind == crcd_pkg::CRCD_KIND_NONE || !sel_ok) begin
        cmd_unknown_nxt = 1'b1;
      end else begin
        reg_onehot_nxt = 4'h1 << sel;
        if (kind == crcd_pkg::CRCD_KIND_OFFSET) begin
          offset_rd_nxt = is_read;
          offset_wr_nxt = !is_read;
        end else begin
          gain_rd_nxt = is_read;
          gain_wr_nxt = !is_read;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      offset_wr_r <= 1'b0;
      offset_rd_r <= 1'b0;
      gain_wr_r <= 1'b0;
      gain_rd_r <= 1'b0;
      cmd_unknown_r <= 1'b0;
      reg_onehot_r <= 4'h0;
    end else begin
      offset_wr_r <= offset_wr_nxt;
      offset_rd_r <= offset_rd_nxt;
      gain_wr_r <= gain_wr_nxt;
      gain_rd_r <= gain_rd_nxt;
      cmd_unknown_r <= cmd_unknown_nxt;
      reg_onehot_r <= reg_onehot_nxt;
    end
  end

  assign offset_wr = offset_wr_r;
  assign offset_rd = offset_rd_r;
  assign gain_wr = gain_wr_r;
  assign gain_rd = gain_rd_r;
  assign cmd_unknown = cmd_unknown_r;
  assign reg_onehot = reg_onehot_r;

  // Checks
  // Offset access byte
  sequence s_off_cmd;
    cmd_valid && cmd_byte[7:6] == 2'h0 && cmd_byte[2:0] == 3'h1;
  endsequence

  // Gain access byte
  sequence s_gain_cmd;
    cmd_valid && cmd_byte[7:6] == 2'h0 && cmd_byte[2:0] == 3'h2;
  endsequence

  // Top bits other than zero
  sequence s_bad_top;
    cmd_valid && cmd_byte[7:6] != 2'h0;
  endsequence

  // Top bits right, low bits match neither access
  sequence s_bad_low;
    cmd_valid && cmd_byte[7:6] == 2'h0 && cmd_byte[2:0] != 3'h1 && cmd_byte[2:0] != 3'h2;
  endsequence

  sequence s_rd_bit;
    cmd_byte[3] == 1'h1;
  endsequence

  sequence s_wr_bit;
    cmd_byte[3] == 1'h0;
  endsequence

  // Select codes of registers one and two
  sequence s_sel_low_pair;
    cmd_byte[5] == 1'h0;
  endsequence

  // Select codes of registers three and four
  sequence s_sel_high_pair;
    cmd_byte[5] == 1'h1;
  endsequence

  sequence s_no_strobe;
    !offset_wr && !offset_rd && !gain_wr && !gain_rd;
  endsequence

  sequence s_all_clear;
    !offset_wr && !offset_rd && !gain_wr && !gain_rd && !cmd_unknown && reg_onehot == 4'h0;
  endsequence

  // Offset access
  chk_rw_direction: assert property (@(posedge clk_sys) disable iff (reset)
    (s_off_cmd and s_rd_bit and s_sel_low_pair) |=> offset_rd && !offset_wr)
    else $error("offset read byte did not give a read");

  chk_offset_zero_sel: assert property (@(posedge clk_sys) disable iff (reset)
    (s_off_cmd and s_sel_low_pair and (cmd_byte[4] == 1'h0)) |=> reg_onehot == 4'h1)
    else $error("offset select 00 did not pick register one");

  chk_offset_low_sel: assert property (@(posedge clk_sys) disable iff (reset)
    (s_off_cmd and (cmd_byte[5:4] == 2'h1)) |=> reg_onehot == 4'h2)
    else $error("offset select 01 did not pick register two");

  chk_offset_high_sel: assert property (@(posedge clk_sys) disable iff (reset)
    (s_off_cmd and s_sel_high_pair) |=> (NUM_CHANNELS == 4)
      ? ((offset_rd || offset_wr) && reg_onehot == (4'h4 << $past(cmd_byte[4])))
      : (cmd_unknown && reg_onehot == 4'h0))
    else $error("offset select 1x mishandled");

  chk_offset_detect: assert property (@(posedge clk_sys) disable iff (reset)
    (s_off_cmd and s_sel_low_pair and s_wr_bit) |=> offset_wr && !gain_wr)
    else $error("offset write byte not recognised");

  chk_offset_read_only: assert property (@(posedge clk_sys) disable iff (reset)
    (s_off_cmd and s_rd_bit) |=> !offset_wr && !gain_wr && !gain_rd)
    else $error("offset read byte gave a write or gain strobe");

  // Gain access
  chk_gain_detect: assert property (@(posedge clk_sys) disable iff (reset)
    (s_gain_cmd and s_sel_low_pair) |=> (gain_rd || gain_wr) && !offset_rd && !offset_wr)
    else $error("gain byte not recognised");

  chk_gain_sel: assert property (@(posedge clk_sys) disable iff (reset)
    (s_gain_cmd and (cmd_byte[5:4] == 2'h0)) |=> reg_onehot == 4'h1)
    else $error("gain select 00 did not pick register one");

  chk_gain_sel_two: assert property (@(posedge clk_sys) disable iff (reset)
    (s_gain_cmd and (cmd_byte[5:4] == 2'h1)) |=> reg_onehot == 4'h2)
    else $error("gain select 01 did not pick register two");

  chk_gain_high_sel: assert property (@(posedge clk_sys) disable iff (reset)
    (s_gain_cmd and s_sel_high_pair) |=> (NUM_CHANNELS == 4)
      ? ((gain_rd || gain_wr) && reg_onehot == (4'h4 << $past(cmd_byte[4])))
      : (cmd_unknown && !gain_rd && !gain_wr && reg_onehot == 4'h0))
    else $error("gain select 1x mishandled");

  chk_gain_read_bit: assert property (@(posedge clk_sys) disable iff (reset)
    (s_gain_cmd and s_rd_bit and s_sel_low_pair) |=> gain_rd && !gain_wr)
    else $error("gain read byte did not give a read");

  chk_gain_write_bit: assert property (@(posedge clk_sys) disable iff (reset)
    (s_gain_cmd and s_wr_bit and s_sel_low_pair) |=> gain_wr && !gain_rd)
    else $error("gain write byte did not give a write");

  chk_gain_read_only: assert property (@(posedge clk_sys) disable iff (reset)
    (s_gain_cmd and s_rd_bit) |=> !gain_wr && !offset_wr && !offset_rd)
    else $error("gain read byte gave a write or offset strobe");

  // Refused bytes
  chk_top_refused: assert property (@(posedge clk_sys) disable iff (reset)
    s_bad_top |=> s_no_strobe and (cmd_unknown && reg_onehot == 4'h0))
    else $error("byte with nonzero top bits was not refused");

  chk_low_refused: assert property (@(posedge clk_sys) disable iff (reset)
    s_bad_low |=> s_no_strobe and (cmd_unknown && reg_onehot == 4'h0))
    else $error("byte with unmatched low bits was not refused");

  chk_unknown_no_reg: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_unknown |-> s_no_strobe and (reg_onehot == 4'h0))
    else $error("refused byte also gave an access");

  // Output framing
  chk_idle_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    !cmd_valid |=> s_all_clear)
    else $error("output raised without a byte");

  chk_single_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    $onehot0({offset_wr, offset_rd, gain_wr, gain_rd, cmd_unknown}))
    else $error("more than one strobe at once");

  chk_onehot_valid: assert property (@(posedge clk_sys) disable iff (reset)
    (offset_wr || offset_rd || gain_wr || gain_rd) |-> $onehot(reg_onehot))
    else $error("register number not one-hot with a strobe");

  chk_answer_delay: assert property (@(posedge clk_sys) disable iff (reset)
    (offset_wr || offset_rd || gain_wr || gain_rd || cmd_unknown) |-> $past(cmd_valid))
    else $error("output not one cycle after a byte");
endmodule

/* crcd_decoder_tb_top.sv */
`timescale 1ns/1ps
module crcd_decoder_tb_top;
  logic clk_sys = 1'b0, reset = 1'b1, req = 1'b0, cmd_valid;
  logic [7:0] bval = 8'h00, cmd_byte;
  logic offset_wr, offset_rd, gain_wr, gain_rd, cmd_unknown;
  logic [3:0] reg_onehot;
  logic owr_two, ord_two, gwr_two, grd_two, unk_two;
  logic [3:0] onehot_two;
  logic [8:0] got_four, got_two;
  logic [8:0] e0 = 9'h000, e1 = 9'h000, f0 = 9'h000, f1 = 9'h000;
  int miscompares = 0, n_checks = 0, seed = 54;
  always #5 clk_sys = ~clk_sys;
  crcd_host_model crcd_host_model_inst (.clk_sys(clk_sys), .req(req), .bval(bval),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));
  crcd_decoder #(.NUM_CHANNELS(4)) crcd_decoder_inst (.clk_sys(clk_sys), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .offset_wr(offset_wr),
    .offset_rd(offset_rd), .gain_wr(gain_wr), .gain_rd(gain_rd),
    .reg_onehot(reg_onehot), .cmd_unknown(cmd_unknown));
  // Two-channel variant on the same byte stream
  crcd_decoder #(.NUM_CHANNELS(2)) crcd_decoder_two_inst (.clk_sys(clk_sys), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .offset_wr(owr_two),
    .offset_rd(ord_two), .gain_wr(gwr_two), .gain_rd(grd_two),
    .reg_onehot(onehot_two), .cmd_unknown(unk_two));
  assign got_four = {offset_wr, offset_rd, gain_wr, gain_rd, reg_onehot, cmd_unknown};
  assign got_two = {owr_two, ord_two, gwr_two, grd_two, onehot_two, unk_two};
  // Expected strobes, one-hot select and unknown flag for one byte
  function automatic logic [8:0] exp_out(input logic [7:0] b, input int nch);
    logic [3:0] oh;
    oh = 4'h1 << b[5:4];
    if (nch == 2 && b[5]) return 9'h001;
    if (b[7:6] == 2'h0 && b[2:0] == 3'h1) return {~b[3], b[3], 2'h0, oh, 1'b0};
    if (b[7:6] == 2'h0 && b[2:0] == 3'h2) return {2'h0, ~b[3], b[3], oh, 1'b0};
    return 9'h001;
  endfunction
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #50000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    for (int i = 0; i < 600; i++) begin
      @(negedge clk_sys);
      #1;
      chk(got_four, e1);
      chk(got_two, f1);
      e1 = e0;
      f1 = f0;
      // A byte in flight when reset rises must leave no trace
      req = (i < 256 || i == 399) ? 1'b1 : 1'($random(seed));
      bval = (i < 256) ? 8'(i) : 8'($random(seed));
      e0 = (req && (i < 399 || i > 401)) ? exp_out(bval, 4) : 9'h000;
      f0 = (req && (i < 399 || i > 401)) ? exp_out(bval, 2) : 9'h000;
      reset = (i >= 400 && i < 403);
    end
    stop_test;
  end
endmodule

/* crcd_host_model.sv */
`timescale 1ns/1ps
module crcd_host_model (
  input wire logic clk_sys,
  input wire logic req,
  input wire logic [7:0] bval,
  output logic cmd_valid,
  output logic [7:0] cmd_byte
);
  // Idle byte lines toggle so stale values never look valid
  always @(negedge clk_sys) begin
    cmd_valid <= req;
    cmd_byte <= req ? bval : ~cmd_byte;
  end
endmodule

/* crcd_map.svh */
`ifndef CRCD_MAP_SVH
`define CRCD_MAP_SVH
`define CRCD_TOP_BITS 2'h0
`define CRCD_LOW_OFFSET 3'h1
`define CRCD_LOW_GAIN 3'h2
`define CRCD_RW_BIT 3
`define CRCD_SEL_HI_BIT 5
`define CRCD_SEL_LO_BIT 4
`define CRCD_RW_WRITE 1'h0
`define CRCD_RW_READ 1'h1
`endif

/* crcd_pkg.sv */
package crcd_pkg;
  typedef enum logic [1:0] {
    CRCD_KIND_NONE = 2'b00,
    CRCD_KIND_OFFSET = 2'b01,
    CRCD_KIND_GAIN = 2'b11
  } crcd_kind_e;
  typedef logic [1:0] crcd_sel_t;
endpackage
